// ---- verilog/mic_ctrl.sv ----
/*
 mac interface control register: holds the mac side interface
 configuration, decodes it for the datapath, reports rx fifo over and
 underflow, and shapes the rmii carrier / data valid signal.
 assumes a plain register port (strobes, read data one cycle later),
 fifo event pulses and carrier inputs synchronous to clk_i.
*/
`default_nettype none
`include "mic_map.svh"
module mic_ctrl
    import mic_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ce_i,
    // register port
    input  wire logic [`MIC_ADDR_W-1:0] addr_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [15:0]            rdata_o,
    // strap pins
    input  wire logic                   strap_rx_dly_i,
    input  wire logic                   strap_tx_dly_i,
    input  wire logic                   strap_rgmii_i,
    input  wire logic                   strap_clk50_i,
    input  wire logic                   strap_rmii_i,
    // rx fifo events
    input  wire logic                   fifo_ovf_i,
    input  wire logic                   fifo_unf_i,
    // rmii receive side
    input  wire logic                   crs_i,
    input  wire logic                   rx_data_vld_i,
    output logic                        crs_dv_o,
    // decoded configuration
    output mic_mode_e                   mode_o,
    output logic                        rx_clk_dly_o,
    output logic                        tx_clk_dly_o,
    output logic                        ref_clk_50_o,
    output logic                        rmii_rev10_o,
    output logic      [3:0]             sgmii_thr_bits_o,
    output logic      [2:0]             eb_tol_bits_o
);
    // strap capture outputs
    logic [`MIC_STRAP_W-1:0] strap_vec;   // strap pins as a vector
    logic [`MIC_STRAP_W-1:0] strap_val;   // captured levels
    logic                    strap_vld;   // load pulse

    // decoded bus strobes
    logic                    hit;         // address matches register
    logic                    wr_hit;      // write to register
    logic                    rd_hit;      // read of register, clears flags

    // sticky event flags
    logic                    ovf_seen;    // overflow since last read
    logic                    unf_seen;    // underflow since last read

    // register fields
    logic [1:0]              thr_reg;     // sgmii half-full threshold
    logic [1:0]              thr_next;
    logic                    rxd_reg;     // rgmii rx clock delay
    logic                    rxd_next;
    logic                    txd_reg;     // rgmii tx clock delay
    logic                    txd_next;
    logic                    rsv10_reg;   // reserved, writable
    logic                    rsv10_next;
    logic                    rgmii_reg;   // rgmii enable
    logic                    rgmii_next;
    logic                    rsv8_reg;    // reserved, writable
    logic                    rsv8_next;
    logic                    clk50_reg;   // reference clock select
    logic                    clk50_next;
    logic                    rsv6_reg;    // reserved, writable, resets 1
    logic                    rsv6_next;
    logic                    rmii_reg;    // rmii enable
    logic                    rmii_next;
    logic                    rev_reg;     // rmii revision select
    logic                    rev_next;
    logic [1:0]              eb_reg;      // elasticity buffer size
    logic [1:0]              eb_next;

    // read path
    mic_word_t               word;        // assembled register image
    logic [15:0]             rdata_reg;
    logic [15:0]             rdata_next;

    // decoded outputs
    mic_mode_e               mode_reg;
    mic_mode_e               mode_next;
    logic                    rxo_reg;
    logic                    rxo_next;
    logic                    txo_reg;
    logic                    txo_next;
    logic                    c50_reg;
    logic                    c50_next;
    logic                    r10_reg;
    logic                    r10_next;
    logic [3:0]              thro_reg;
    logic [3:0]              thro_next;
    logic [2:0]              ebo_reg;
    logic [2:0]              ebo_next;

    // carrier / data valid generator
    mic_crs_state_e          crs_st_reg;
    mic_crs_state_e          crs_st_next;
    logic                    crs_dv_reg;
    logic                    crs_dv_next;

    assign strap_vec[`MIC_S_RXDLY] = strap_rx_dly_i;
    assign strap_vec[`MIC_S_TXDLY] = strap_tx_dly_i;
    assign strap_vec[`MIC_S_RGMII] = strap_rgmii_i;
    assign strap_vec[`MIC_S_CLK50] = strap_clk50_i;
    assign strap_vec[`MIC_S_RMII]  = strap_rmii_i;

    // strap levels latched once after reset release
    mic_strap_cap u_strap (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .strap_i     (strap_vec),
        .strap_val_o (strap_val),
        .strap_vld_o (strap_vld)
    );

    // address decode; strobes are ignored while clock enable is low
    assign hit    = (addr_i == `MIC_CTRL_ADDR);
    assign wr_hit = wr_i && hit;
    assign rd_hit = rd_i && hit && ce_i;

    // overflow flag, cleared by reading the register
    mic_cor_flag u_ovf (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .set_i   (fifo_ovf_i),
        .clr_i   (rd_hit),
        .flag_o  (ovf_seen)
    );

    // underflow flag, cleared by reading the register
    mic_cor_flag u_unf (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .set_i   (fifo_unf_i),
        .clr_i   (rd_hit),
        .flag_o  (unf_seen)
    );

    // field next values: strap load beats a write in the same cycle
    always_comb begin
        thr_next   = thr_reg;
        rxd_next   = rxd_reg;
        txd_next   = txd_reg;
        rsv10_next = rsv10_reg;
        rgmii_next = rgmii_reg;
        rsv8_next  = rsv8_reg;
        clk50_next = clk50_reg;
        rsv6_next  = rsv6_reg;
        rmii_next  = rmii_reg;
        rev_next   = rev_reg;
        eb_next    = eb_reg;
        if (strap_vld) begin
            rxd_next   = strap_val[`MIC_S_RXDLY];
            txd_next   = strap_val[`MIC_S_TXDLY];
            rgmii_next = strap_val[`MIC_S_RGMII];
            clk50_next = strap_val[`MIC_S_CLK50];
            rmii_next  = strap_val[`MIC_S_RMII];
        end else if (wr_hit) begin
            // bit 15 and the two status bits are read only
            thr_next   = wdata_i[`MIC_B_THR_HI:`MIC_B_THR_LO];
            rxd_next   = wdata_i[`MIC_B_RXDLY];
            txd_next   = wdata_i[`MIC_B_TXDLY];
            rsv10_next = wdata_i[`MIC_B_RSV10];
            rgmii_next = wdata_i[`MIC_B_RGMII];
            rsv8_next  = wdata_i[`MIC_B_RSV8];
            clk50_next = wdata_i[`MIC_B_CLK50];
            rsv6_next  = wdata_i[`MIC_B_RSV6];
            rmii_next  = wdata_i[`MIC_B_RMII];
            rev_next   = wdata_i[`MIC_B_REV10];
            eb_next    = wdata_i[`MIC_B_EB_HI:`MIC_B_EB_LO];
        end
    end

    // field registers; strap fields sit at zero until the load pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thr_reg   <= `MIC_THR_RST;
            rxd_reg   <= 1'b0;
            txd_reg   <= 1'b0;
            rsv10_reg <= 1'b0;
            rgmii_reg <= 1'b0;
            rsv8_reg  <= 1'b0;
            clk50_reg <= 1'b0;
            rsv6_reg  <= `MIC_RSV6_RST;
            rmii_reg  <= 1'b0;
            rev_reg   <= `MIC_REV_RST;
            eb_reg    <= `MIC_EB_RST;
        end else if (ce_i) begin
            thr_reg   <= thr_next;
            rxd_reg   <= rxd_next;
            txd_reg   <= txd_next;
            rsv10_reg <= rsv10_next;
            rgmii_reg <= rgmii_next;
            rsv8_reg  <= rsv8_next;
            clk50_reg <= clk50_next;
            rsv6_reg  <= rsv6_next;
            rmii_reg  <= rmii_next;
            rev_reg   <= rev_next;
            eb_reg    <= eb_next;
        end
    end

    // register image; status bits read 1 until an event is seen
    always_comb begin
        word                                = '0;
        word[`MIC_B_THR_HI:`MIC_B_THR_LO]   = thr_reg;
        word[`MIC_B_RXDLY]                  = rxd_reg;
        word[`MIC_B_TXDLY]                  = txd_reg;
        word[`MIC_B_RSV10]                  = rsv10_reg;
        word[`MIC_B_RGMII]                  = rgmii_reg;
        word[`MIC_B_RSV8]                   = rsv8_reg;
        word[`MIC_B_CLK50]                  = clk50_reg;
        word[`MIC_B_RSV6]                   = rsv6_reg;
        word[`MIC_B_RMII]                   = rmii_reg;
        word[`MIC_B_REV10]                  = rev_reg;
        word[`MIC_B_OVF]                    = ~ovf_seen;
        word[`MIC_B_UNF]                    = ~unf_seen;
        word[`MIC_B_EB_HI:`MIC_B_EB_LO]     = eb_reg;
    end

    // read data stand only in the cycle after the strobe; unmapped reads 0
    always_comb begin
        rdata_next = 16'h0000;
        if (rd_hit) begin
            rdata_next = word;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 16'h0000;
        end else if (ce_i) begin
            rdata_reg <= rdata_next;
        end
    end

    // decode of the configuration toward the datapath
    always_comb begin
        // rgmii enable overrides the rmii bit
        if (rgmii_reg) begin
            mode_next = MIC_MODE_RGMII;
        end else if (rmii_reg) begin
            mode_next = MIC_MODE_RMII;
        end else begin
            mode_next = MIC_MODE_MII;
        end
        // the 2 ns delay itself is a delay line outside this logic
        rxo_next = rxd_reg;
        txo_next = txd_reg;
        c50_next = clk50_reg;
        r10_next = rev_reg;
        case (thr_reg)
            2'h0:    thro_next = `MIC_THR_00;
            2'h1:    thro_next = `MIC_THR_01;
            2'h2:    thro_next = `MIC_THR_10;
            default: thro_next = `MIC_THR_11;
        endcase
        // smallest setting still covers normal frames at 100 ppm
        case (eb_reg)
            2'h0:    ebo_next = `MIC_EB_00;
            2'h1:    ebo_next = `MIC_EB_01;
            2'h2:    ebo_next = `MIC_EB_10;
            default: ebo_next = `MIC_EB_11;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= MIC_MODE_MII;
            rxo_reg  <= 1'b0;
            txo_reg  <= 1'b0;
            c50_reg  <= 1'b0;
            r10_reg  <= 1'b0;
            thro_reg <= `MIC_THR_10;
            ebo_reg  <= `MIC_EB_01;
        end else if (ce_i) begin
            mode_reg <= mode_next;
            rxo_reg  <= rxo_next;
            txo_reg  <= txo_next;
            c50_reg  <= c50_next;
            r10_reg  <= r10_next;
            thro_reg <= thro_next;
            ebo_reg  <= ebo_next;
        end
    end

    // carrier / data valid: carrier phase, then a tail while data drains
    always_comb begin
        crs_st_next = crs_st_reg;
        crs_dv_next = 1'b0;
        case (crs_st_reg)
            MIC_CRS_IDLE: begin
                if (crs_i) begin
                    crs_st_next = MIC_CRS_CARRIER;
                    crs_dv_next = 1'b1;
                end
            end
            MIC_CRS_CARRIER: begin
                crs_dv_next = 1'b1;
                if (!crs_i && rx_data_vld_i) begin
                    crs_st_next = MIC_CRS_TAIL;
                    crs_dv_next = rev_reg;
                end else if (!crs_i) begin
                    crs_st_next = MIC_CRS_IDLE;
                    crs_dv_next = 1'b0;
                end
            end
            MIC_CRS_TAIL: begin
                if (!rx_data_vld_i) begin
                    crs_st_next = MIC_CRS_IDLE;
                    crs_dv_next = 1'b0;
                end else if (rev_reg) begin
                    crs_dv_next = 1'b1;
                end else begin
                    crs_dv_next = ~crs_dv_reg;
                end
            end
            default: begin
                crs_st_next = MIC_CRS_IDLE;
                crs_dv_next = 1'b0;
            end
        endcase
        // outside rmii the generator is parked; mii uses its own pins
        if (mode_reg != MIC_MODE_RMII) begin
            crs_st_next = MIC_CRS_IDLE;
            crs_dv_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crs_st_reg <= MIC_CRS_IDLE;
            crs_dv_reg <= 1'b0;
        end else if (ce_i) begin
            crs_st_reg <= crs_st_next;
            crs_dv_reg <= crs_dv_next;
        end
    end

    assign rdata_o          = rdata_reg;
    assign crs_dv_o         = crs_dv_reg;
    assign mode_o           = mode_reg;
    assign rx_clk_dly_o     = rxo_reg;
    assign tx_clk_dly_o     = txo_reg;
    assign ref_clk_50_o     = c50_reg;
    assign rmii_rev10_o     = r10_reg;
    assign sgmii_thr_bits_o = thro_reg;
    assign eb_tol_bits_o    = ebo_reg;
endmodule
`default_nettype wire

// ---- verilog/mic_map.svh ----
/*
 holds the address, field positions, reset values and decode figures
 of the mac interface control register.
 assumes it is included by bare name into the design files.
*/
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH

`define MIC_ADDR_W     5
`define MIC_CTRL_ADDR  5'h17
`define MIC_STRAP_W    5

`define MIC_B_RSV15    15
`define MIC_B_THR_HI   14
`define MIC_B_THR_LO   13
`define MIC_B_RXDLY    12
`define MIC_B_TXDLY    11
`define MIC_B_RSV10    10
`define MIC_B_RGMII    9
`define MIC_B_RSV8     8
`define MIC_B_CLK50    7
`define MIC_B_RSV6     6
`define MIC_B_RMII     5
`define MIC_B_REV10    4
`define MIC_B_OVF      3
`define MIC_B_UNF      2
`define MIC_B_EB_HI    1
`define MIC_B_EB_LO    0

`define MIC_S_RXDLY    4
`define MIC_S_TXDLY    3
`define MIC_S_RGMII    2
`define MIC_S_CLK50    1
`define MIC_S_RMII     0

`define MIC_THR_RST    2'h2
`define MIC_EB_RST     2'h1
`define MIC_RSV6_RST   1'h1
`define MIC_REV_RST    1'h0

`define MIC_THR_00     4'h5
`define MIC_THR_01     4'h2
`define MIC_THR_10     4'h6
`define MIC_THR_11     4'hA
`define MIC_EB_00      3'h5
`define MIC_EB_01      3'h2
`define MIC_EB_10      3'h3
`define MIC_EB_11      3'h4

`endif

// ---- verilog/mic_pkg.sv ----
/*
 types shared by the mac interface control register files.
 assumes nothing of its surroundings.
*/
`default_nettype none
package mic_pkg;
    // interface flavour driven toward the mac side datapath
    typedef enum logic [1:0] {
        MIC_MODE_MII,
        MIC_MODE_RMII,
        MIC_MODE_RGMII
    } mic_mode_e;

    // carrier / data valid generator states
    typedef enum logic [1:0] {
        MIC_CRS_IDLE,
        MIC_CRS_CARRIER,
        MIC_CRS_TAIL
    } mic_crs_state_e;

    typedef logic [15:0] mic_word_t;
endpackage
`default_nettype wire

// ---- verilog/mic_cor_flag.sv ----
/*
 one sticky event flag, cleared by a register read.
 assumes set and clear are one-cycle pulses in the clk_i domain.
*/
`default_nettype none
module mic_cor_flag
    import mic_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    logic flag_reg;   // event seen since last read
    logic flag_next;

    // set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        flag_next = flag_reg;
        if (set_i) begin
            flag_next = 1'b1;
        end else if (clr_i) begin
            flag_next = 1'b0;
        end
    end

    // register only; frozen while clock enable is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= 1'b0;
        end else if (ce_i) begin
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;
endmodule
`default_nettype wire

// ---- verilog/mic_strap_cap.sv ----
/*
 catches the strap pin levels once, at the first enabled edge after reset.
 assumes straps are stable around reset release and synchronous to clk_i.
*/
`default_nettype none
`include "mic_map.svh"
module mic_strap_cap
    import mic_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    input  wire logic [`MIC_STRAP_W-1:0] strap_i,
    output logic      [`MIC_STRAP_W-1:0] strap_val_o,
    output logic                         strap_vld_o
);
    logic [`MIC_STRAP_W-1:0] val_reg;   // latched strap levels
    logic [`MIC_STRAP_W-1:0] val_next;
    logic                    done_reg;  // capture already taken
    logic                    done_next;
    logic                    vld_reg;   // one-cycle load pulse
    logic                    vld_next;

    // capture happens in a clocked process, never inside the reset branch
    always_comb begin
        val_next  = val_reg;
        done_next = done_reg;
        vld_next  = 1'b0;
        if (!done_reg) begin
            val_next  = strap_i;
            done_next = 1'b1;
            vld_next  = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            val_reg  <= '0;
            done_reg <= 1'b0;
            vld_reg  <= 1'b0;
        end else if (ce_i) begin
            val_reg  <= val_next;
            done_reg <= done_next;
            vld_reg  <= vld_next;
        end
    end

    assign strap_val_o = val_reg;
    assign strap_vld_o = vld_reg;
endmodule
`default_nettype wire

// ---- verification/mic_rx_model.sv ----
/*
 receive path model: one frame of carrier, then data still pending.
 assumes go_i is a one-cycle pulse driven on the clk_i rising edge.
*/
`default_nettype none
module mic_rx_model #(
    parameter int CRS_N  = 3, // carrier cycles
    parameter int TAIL_N = 4  // pending data cycles after carrier drops
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic go_i,
    output logic      crs_o,
    output logic      vld_o
);
    logic [4:0] cnt_reg;  // frame position, zero when idle
    logic [4:0] cnt_next;
    // restart on go, else run to the frame end
    always_comb begin
        cnt_next = 5'h00;
        if (go_i) begin
            cnt_next = 5'h01;
        end else if (cnt_reg != 5'h00 && cnt_reg < 5'(CRS_N + TAIL_N)) begin
            cnt_next = cnt_reg + 5'h01;
        end
    end
    // register only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    // both lines low outside a frame
    assign crs_o = cnt_reg != 5'h00 && cnt_reg <= 5'(CRS_N);
    assign vld_o = cnt_reg > 5'(CRS_N);
endmodule
`default_nettype wire

// ---- verification/mic_ctrl_asserts.sv ----
/*
 port checks of the mac interface control register.
 assumes it is bound to mic_ctrl, one clock domain.
*/
`default_nettype none
`include "mic_map.svh"
module mic_ctrl_asserts
    import mic_pkg::*;
(
    input wire logic                   clk_i,
    input wire logic                   rst_n_i,
    input wire logic                   ce_i,
    input wire logic [`MIC_ADDR_W-1:0] addr_i,
    input wire logic [15:0]            wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [15:0]            rdata_o,
    input wire logic                   fifo_ovf_i,
    input wire logic                   fifo_unf_i,
    input wire logic                   crs_i,
    input wire logic                   rx_data_vld_i,
    input wire logic                   crs_dv_o,
    input wire mic_mode_e              mode_o,
    input wire logic                   rx_clk_dly_o,
    input wire logic                   tx_clk_dly_o,
    input wire logic                   ref_clk_50_o,
    input wire logic                   rmii_rev10_o,
    input wire logic [3:0]             sgmii_thr_bits_o,
    input wire logic [2:0]             eb_tol_bits_o
);
    localparam logic [3:0] THR [4] = '{4'h5, 4'h2, 4'h6, 4'hA}; // threshold bits per code
    localparam logic [2:0] EB [4]  = '{3'h5, 3'h2, 3'h3, 3'h4}; // tolerance bits per code
    logic [15:0] wd_q;  // write data one edge back
    logic [15:0] wd_q2; // write data two edges back
    logic        wr_q;  // write strobe one edge back
    wire is_reg = addr_i == `MIC_CTRL_ADDR;
    // rev and mode outputs lag a write, so skip two edges after one
    wire quiet = !wr_i && !wr_q;
    wire ev = fifo_ovf_i || fifo_unf_i;
    wire rm12 = mode_o == MIC_MODE_RMII && !rmii_rev10_o && quiet;
    wire tl = rm12 && !crs_i && rx_data_vld_i;
    // history for the decode checks
    always_ff @(posedge clk_i) begin
        wd_q <= wdata_i;
        wd_q2 <= wd_q;
        wr_q <= wr_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr;
        ce_i && wr_i && is_reg;
    endsequence
    sequence s_set;
        s_wr ##1 (ce_i && !(wr_i && is_reg));
    endsequence
    sequence s_rd;
        ce_i && rd_i && is_reg;
    endsequence
    AST_THR: assert property (s_set |=> sgmii_thr_bits_o == THR[wd_q2[14:13]])
        else $error("threshold decode wrong");
    AST_EB: assert property (s_set |=> eb_tol_bits_o == EB[wd_q2[1:0]])
        else $error("elasticity decode wrong");
    AST_MODE: assert property (s_set |=> mode_o == (wd_q2[9] ? MIC_MODE_RGMII :
        (wd_q2[5] ? MIC_MODE_RMII : MIC_MODE_MII))) else $error("mode decode wrong");
    AST_DLY: assert property (s_set |=> {rx_clk_dly_o, tx_clk_dly_o} == wd_q2[12:11])
        else $error("delay enables wrong");
    AST_CLK: assert property (s_set |=> ref_clk_50_o == wd_q2[7])
        else $error("clock select wrong");
    AST_OVF: assert property (ce_i && fifo_ovf_i ##1 s_rd |=> !rdata_o[3])
        else $error("overflow not reported");
    AST_UNF: assert property (ce_i && fifo_unf_i ##1 s_rd |=> !rdata_o[2])
        else $error("underflow not reported");
    AST_COR: assert property ((s_rd and !ev) ##1 (!rd_i && !ev) ##1 s_rd |=> rdata_o[3:2] == 2'h3)
        else $error("status not cleared by read");
    AST_HOLD: assert property (mode_o == MIC_MODE_RMII && rmii_rev10_o && quiet && crs_dv_o
        && (crs_i || rx_data_vld_i) |=> crs_dv_o) else $error("carrier valid dropped early");
    AST_TGDN: assert property (rm12 && crs_dv_o && !crs_i |=> !crs_dv_o)
        else $error("carrier valid not lowered");
    AST_TGUP: assert property ((tl && crs_dv_o) ##1 (tl && !crs_dv_o) |=> crs_dv_o)
        else $error("carrier valid not toggling");
endmodule
bind mic_ctrl mic_ctrl_asserts u_chk (.clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .fifo_ovf_i, .fifo_unf_i, .crs_i, .rx_data_vld_i, .crs_dv_o, .mode_o, .rx_clk_dly_o,
    .tx_clk_dly_o, .ref_clk_50_o, .rmii_rev10_o, .sgmii_thr_bits_o, .eb_tol_bits_o);
`default_nettype wire

// ---- verification/mac_interface_config_register_bench.sv ----
/*
 self-checking bench of the mac interface control register.
 assumes the design, the receive model and the checker are compiled first.
*/
`default_nettype none
`include "mic_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module mac_interface_config_register_bench
    import mic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CRS_N  = 3;
    localparam int TAIL_N = 4;
    localparam logic [3:0] THR [4] = '{4'h5, 4'h2, 4'h6, 4'hA};
    localparam logic [2:0] EB [4]  = '{3'h5, 3'h2, 3'h3, 3'h4};
    logic        clk_i, rst_n_i, wr_i, rd_i, ovf, unf, go, crs, vld, crs_dv_o;
    logic        rx_dly, tx_dly, clk50, rev10;
    logic [4:0]  addr_i, strap;
    logic [15:0] wdata_i, rdata_o, q, d, seed;
    logic [15:0] img; // expected register image
    logic [3:0]  thr;
    logic [2:0]  eb;
    mic_mode_e   mode;
    int          n_mismatch, checks;
    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    mic_ctrl dut (.clk_i, .rst_n_i, .ce_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .strap_rx_dly_i(strap[4]), .strap_tx_dly_i(strap[3]), .strap_rgmii_i(strap[2]),
        .strap_clk50_i(strap[1]), .strap_rmii_i(strap[0]), .fifo_ovf_i(ovf), .fifo_unf_i(unf),
        .crs_i(crs), .rx_data_vld_i(vld), .crs_dv_o, .mode_o(mode), .rx_clk_dly_o(rx_dly),
        .tx_clk_dly_o(tx_dly), .ref_clk_50_o(clk50), .rmii_rev10_o(rev10),
        .sgmii_thr_bits_o(thr), .eb_tol_bits_o(eb));
    mic_rx_model #(.CRS_N(CRS_N), .TAIL_N(TAIL_N)) u_rx (.clk_i, .rst_n_i, .go_i(go),
        .crs_o(crs), .vld_o(vld));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected carrier valid k cycles after the frame starts
    function automatic logic exp_dv(input logic rm, input logic rv, input int k);
        if (!rm || k == 0 || k > CRS_N + TAIL_N) return 1'b0;
        if (k <= CRS_N || rv) return 1'b1;
        return 1'(((k - CRS_N) % 2) == 0);
    endfunction
    task automatic end_of_test;
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // optional event pulse, then a read right after it
    task automatic ev_rd(input logic [4:0] a, input logic o, input logic u);
        if (o || u) begin
            @(posedge clk_i);
            ovf <= o;
            unf <= u;
        end
        @(posedge clk_i);
        ovf <= 1'b0;
        unf <= 1'b0;
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask
    task automatic chk_dec;
        `CHK(thr, THR[img[14:13]])
        `CHK(eb, EB[img[1:0]])
        `CHK(mode, img[9] ? MIC_MODE_RGMII : (img[5] ? MIC_MODE_RMII : MIC_MODE_MII))
        `CHK({rx_dly, tx_dly}, img[12:11])
        `CHK(clk50, img[7])
        `CHK(rev10, img[4])
    endtask
    // reset, random straps, check strap image
    task automatic do_reset;
        rst_n_i <= 1'b0;
        seed = lfsr(seed);
        strap <= seed[4:0];
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        img = {3'b010, seed[4:3], 1'b0, seed[2], 1'b0, seed[1], 1'b1, seed[0], 1'b0, 4'hD};
        ev_rd(`MIC_CTRL_ADDR, 1'b0, 1'b0);
        `CHK(q, img)
        chk_dec();
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {rst_n_i, wr_i, rd_i, ovf, unf, go} = '0;
        addr_i = 5'h00;
        wdata_i = 16'h0000;
        strap = 5'h00;
        seed = 16'h11A0;
        n_mismatch = 0;
        checks = 0;
        do_reset();
        // all size codes and modes
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d = seed;
            d[14:13] = 2'(i);
            d[1:0] = 2'(i);
            d[9] = 1'(i == 3);
            d[5] = i[0];
            wr(`MIC_CTRL_ADDR, d);
            img = {1'b0, d[14:4], img[3:2], d[1:0]};
            ev_rd(`MIC_CTRL_ADDR, 1'b0, 1'b0);
            `CHK(q, img)
            chk_dec();
        end
        // unmapped: write lost, read 0
        wr(5'h16, 16'hFFFF);
        ev_rd(5'h16, 1'b0, 1'b0);
        `CHK(q, 16'h0000)
        // flags report, clear on read
        ev_rd(`MIC_CTRL_ADDR, 1'b1, 1'b0);
        `CHK(q, img & 16'hFFF7)
        ev_rd(`MIC_CTRL_ADDR, 1'b0, 1'b1);
        `CHK(q, img & 16'hFFFB)
        ev_rd(`MIC_CTRL_ADDR, 1'b0, 1'b0);
        `CHK(q, img)
        // frames: rmii 1.2, rmii 1.0, mii
        for (int m = 0; m < 3; m++) begin
            img[9] = 1'b0;
            img[5] = 1'(m < 2);
            img[4] = m[0];
            wr(`MIC_CTRL_ADDR, img);
            @(posedge clk_i);
            go <= 1'b1;
            for (int k = 0; k < 10; k++) begin
                @(posedge clk_i);
                go <= 1'b0;
                #1 `CHK(crs_dv_o, exp_dv(img[5], img[4], k))
            end
        end
        do_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
